/* File: verilog/msel_pkg.sv */
// constants shared by the parallel message select front end
// assumes a 25 MHz system clock
package msel_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned TICK_MS_US = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * TICK_MS_US / 1000;
  localparam int unsigned TENTH_MS = 100;
  localparam logic [7:0] DEB_DC_MS = 8'h05;
  localparam logic [7:0] DEB_AC_MS = 8'h2f;
  localparam logic [7:0] RR_TIME_RST = 8'h05;
  localparam logic [7:0] BLINK_RST = 8'h05;
  localparam logic [7:0] RATE_RST = 8'h05;
  localparam logic [4:0] SAVER_MAX_H = 5'h18;
  localparam logic [11:0] SEC_PER_HOUR = 12'he10;
  localparam logic [3:0] TENTHS_PER_SEC = 4'ha;
  // register offsets (byte addresses, word aligned)
  localparam logic [5:0] REG_PORT = 6'h00;
  localparam logic [5:0] REG_SERIAL = 6'h04;
  localparam logic [5:0] REG_TIMES = 6'h08;
  localparam logic [5:0] REG_RATES = 6'h0c;
  localparam logic [5:0] REG_DATE = 6'h10;
  localparam logic [5:0] REG_TIME = 6'h14;
  localparam logic [5:0] REG_STATUS = 6'h18;
  localparam logic [5:0] REG_SEL = 6'h1c;
  // time set staging bits; go is write-only, freeze reads back at bit 30
  localparam int unsigned SET_GO_BIT = 31;
  localparam int unsigned SET_FREEZE_BIT = 30;
  typedef enum logic [1:0] {MODE_REG, MODE_ROUND, MODE_PRIO, MODE_RSVD} run_mode_e;
endpackage

/* File: verilog/msel_front.sv */
// parallel message select front end with timing configuration
// assumes a classic wishbone master on the same clock; field inputs synchronous
// What this block does
// - parity on gives 7-bit word, else 8
// - date: month 1-12, day 1-31, year 0-99
// - 12h with am/pm or 24h; min/sec 0-59
// - clock frozen during setup, loaded at end
// - date/time set refused without clock fitted
// - polarity: 0 inverted, 1 non-inverted
// - code: 0 BCD, 1 binary
// - width: 0 is 8-bit (only 7 discrete inputs in priority/round robin), 1 is 16-bit
// - width change refused without 16 inputs
// - DC debounce is 5 ms
// - AC debounce is 47 ms
// - variable debounce 1 to 99 ms
// - accept change only after debounce delay
// - run mode: regular, round robin, priority
// - priority: first input wins
// - round robin cycles active inputs, 0-255 tenths
// - without control lines only data inputs count
// - control lines add four discrete inputs
// - saver 0-24 hours, 0 disables
// - saver expiry clears displayed message
// - blink on/off 1-99 tenths, default 5
// - chain/scroll rates 1-255 tenths
// - parity odd 0 or even 1 when enabled
`timescale 1ns/1ps
`default_nettype none
module msel_front
  import msel_pkg::*;
#(
  parameter bit HAS_CLOCK = 1'b1,
  parameter bit HAS_WIDE = 1'b1,
  parameter int unsigned MS_CNT = MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [15:0] discrete_select_inputs_i,
  input wire logic [3:0] control_lines_i,
  input wire logic display_activity_i,
  output logic [15:0] msg_number_o,
  output logic msg_valid_o,
  output logic blink_phase_o,
  output logic chain_tick_o,
  output logic scroll_up_tick_o,
  output logic scroll_left_tick_o
);
  // configuration
  logic polarity_ff, code_ff, width_ff, ctl_in_ff;
  logic [1:0] deb_sel_ff;
  logic [7:0] deb_var_ff;
  run_mode_e mode_ff;
  logic par_en_ff, par_even_ff, word8;
  logic [7:0] rr_time_ff, blink_on_ff, blink_off_ff;
  logic [7:0] rate_chain_ff, rate_up_ff, rate_left_ff;
  logic [4:0] saver_h_ff;
  logic refused_ff;
  // clock state
  logic [3:0] month_ff;
  logic [4:0] day_ff, hour_ff;
  logic [6:0] year_ff;
  logic [5:0] min_ff, sec_ff;
  logic fmt24_ff, frozen_ff;
  logic [3:0] tenth_sec_ff;

  logic wr, rd, acc;
  logic [31:0] wd;
  assign acc = cyc_i && stb_i && !ack_o;
  assign wr = cyc_i && stb_i && we_i && ack_o; // writes land on the edge that sees ack
  assign rd = acc && !we_i;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wd[b*8 +: 8] = sel_i[b] ? dat_i[b*8 +: 8] : 8'h00;
    end
  end

  function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo,
                                       input logic [7:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= acc;
    end
  end

  // configuration writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      polarity_ff <= 1'b0;
      code_ff <= 1'b0;
      width_ff <= HAS_WIDE;
      ctl_in_ff <= 1'b0;
      deb_sel_ff <= 2'h1;
      deb_var_ff <= DEB_DC_MS;
      mode_ff <= MODE_REG;
      par_en_ff <= 1'b0;
      par_even_ff <= 1'b0;
      rr_time_ff <= RR_TIME_RST;
      blink_on_ff <= BLINK_RST;
      blink_off_ff <= BLINK_RST;
      rate_chain_ff <= RATE_RST;
      rate_up_ff <= RATE_RST;
      rate_left_ff <= RATE_RST;
      saver_h_ff <= 5'h00;
      refused_ff <= 1'b0;
    end else if (wr) begin
      unique case (adr_i)
        REG_PORT: begin
          polarity_ff <= wd[0];
          code_ff <= wd[1];
          if (HAS_WIDE) begin
            width_ff <= wd[2];
          end
          refused_ff <= !HAS_WIDE && (wd[2] != width_ff);
          if (wd[5:4] != 2'h0) begin
            deb_sel_ff <= wd[5:4];
          end
          deb_var_ff <= clamp(wd[15:8], 8'h01, 8'h63);
          if (wd[17:16] != 2'h3) begin
            mode_ff <= run_mode_e'(wd[17:16]);
          end
          ctl_in_ff <= wd[18];
        end
        REG_SERIAL: begin
          par_en_ff <= wd[0];
          par_even_ff <= wd[1];
        end
        REG_TIMES: begin
          rr_time_ff <= wd[7:0];
          blink_on_ff <= clamp(wd[15:8], 8'h01, 8'h63);
          blink_off_ff <= clamp(wd[23:16], 8'h01, 8'h63);
          saver_h_ff <= 5'(clamp({3'h0, wd[28:24]}, 8'h00, {3'h0, SAVER_MAX_H}));
        end
        REG_RATES: begin
          rate_chain_ff <= clamp(wd[7:0], 8'h01, 8'hff);
          rate_up_ff <= clamp(wd[15:8], 8'h01, 8'hff);
          rate_left_ff <= clamp(wd[23:16], 8'h01, 8'hff);
        end
        REG_DATE, REG_TIME: begin
          refused_ff <= !HAS_CLOCK;
        end
        default: begin
        end
      endcase
    end
  end

  // word length follows parity enable; mode bit is ignored when parity is off
  assign word8 = !par_en_ff;

  // tick dividers
  logic [$clog2(MS_CYCLES+1)-1:0] ms_cnt_ff;
  logic [6:0] tenth_cnt_ff;
  logic ms_tick, tenth_tick, sec_tick;
  assign ms_tick = (ms_cnt_ff == ($bits(ms_cnt_ff))'(MS_CNT - 1));
  assign tenth_tick = ms_tick && (tenth_cnt_ff == 7'(TENTH_MS - 1));
  assign sec_tick = tenth_tick && (tenth_sec_ff == TENTHS_PER_SEC - 4'h1);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ms_cnt_ff <= '0;
      tenth_cnt_ff <= 7'h00;
      tenth_sec_ff <= 4'h0;
    end else begin
      ms_cnt_ff <= ms_tick ? '0 : ms_cnt_ff + 1'b1;
      if (ms_tick) begin
        tenth_cnt_ff <= tenth_tick ? 7'h00 : tenth_cnt_ff + 7'h01;
      end
      if (tenth_tick) begin
        tenth_sec_ff <= sec_tick ? 4'h0 : tenth_sec_ff + 4'h1;
      end
    end
  end

  // time of day; staged time is loaded only by the final go write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      month_ff <= 4'h1;
      day_ff <= 5'h01;
      year_ff <= 7'h00;
      hour_ff <= 5'h00;
      min_ff <= 6'h00;
      sec_ff <= 6'h00;
      fmt24_ff <= 1'b0;
      frozen_ff <= 1'b0;
    end else if (wr && HAS_CLOCK && adr_i == REG_DATE) begin
      month_ff <= 4'(clamp({4'h0, wd[3:0]}, 8'h01, 8'h0c));
      day_ff <= 5'(clamp({3'h0, wd[12:8]}, 8'h01, 8'h1f));
      year_ff <= 7'(clamp({1'b0, wd[22:16]}, 8'h00, 8'h63));
    end else if (wr && HAS_CLOCK && adr_i == REG_TIME) begin
      frozen_ff <= wd[SET_FREEZE_BIT];
      fmt24_ff <= wd[24];
      if (wd[SET_GO_BIT]) begin
        frozen_ff <= 1'b0;
        hour_ff <= 5'(clamp({3'h0, wd[20:16]}, 8'h00, 8'h17));
        min_ff <= 6'(clamp({2'h0, wd[13:8]}, 8'h00, 8'h3b));
        sec_ff <= 6'(clamp({2'h0, wd[5:0]}, 8'h00, 8'h3b));
      end
    end else if (sec_tick && !frozen_ff && HAS_CLOCK) begin
      if (sec_ff != 6'h3b) begin
        sec_ff <= sec_ff + 6'h01;
      end else begin
        sec_ff <= 6'h00;
        if (min_ff != 6'h3b) begin
          min_ff <= min_ff + 6'h01;
        end else begin
          min_ff <= 6'h00;
          hour_ff <= (hour_ff == 5'h17) ? 5'h00 : hour_ff + 5'h01;
        end
      end
    end
  end

  // 12 hour view: hours 1-12 plus pm flag
  logic [4:0] hour12;
  logic pm;
  assign pm = hour_ff >= 5'h0c;
  always_comb begin
    hour12 = pm ? hour_ff - 5'h0c : hour_ff;
    if (hour12 == 5'h00) begin
      hour12 = 5'h0c;
    end
  end

  // input conditioning and debounce
  logic [19:0] raw, stable_ff, last_ff;
  logic [7:0] deb_cnt_ff, deb_ms;
  assign raw = {control_lines_i, polarity_ff ? discrete_select_inputs_i
                                             : ~discrete_select_inputs_i};
  always_comb begin
    unique case (deb_sel_ff)
      2'h2: deb_ms = DEB_AC_MS;
      2'h3: deb_ms = deb_var_ff;
      default: deb_ms = DEB_DC_MS;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_ff <= 20'h00000;
      stable_ff <= 20'h00000;
      deb_cnt_ff <= 8'h00;
    end else begin
      last_ff <= raw;
      if (raw != last_ff) begin
        deb_cnt_ff <= 8'h00;
      end else if (ms_tick && deb_cnt_ff < deb_ms) begin
        deb_cnt_ff <= deb_cnt_ff + 8'h01;
      end else if (deb_cnt_ff >= deb_ms) begin
        stable_ff <= last_ff;
      end
    end
  end

  // discrete set: data inputs plus optional control lines
  logic [19:0] active;
  always_comb begin
    active = 20'h00000;
    if (width_ff) begin
      active[15:0] = stable_ff[15:0];
    end else begin
      active[6:0] = stable_ff[6:0];
    end
    if (ctl_in_ff) begin
      active[19:16] = stable_ff[19:16];
    end
  end

  function automatic logic [15:0] bcd_to_bin(input logic [15:0] v);
    bcd_to_bin = 16'(v[3:0]) + 16'(v[7:4]) * 16'd10 + 16'(v[11:8]) * 16'd100
                 + 16'(v[15:12]) * 16'd1000;
  endfunction

  logic [15:0] word, par_num;
  assign word = width_ff ? stable_ff[15:0] : {8'h00, stable_ff[7:0]};
  assign par_num = code_ff ? word : bcd_to_bin(word);

  logic [4:0] prio_idx;
  logic prio_any;
  always_comb begin
    prio_idx = 5'h00;
    prio_any = 1'b0;
    for (int i = 19; i >= 0; i--) begin
      if (active[i]) begin
        prio_idx = 5'(i);
        prio_any = 1'b1;
      end
    end
  end

  // round robin pointer steps to the next active input each display period
  logic [4:0] rr_idx_ff;
  logic [7:0] rr_cnt_ff;
  logic [4:0] rr_next;
  always_comb begin
    rr_next = rr_idx_ff;
    for (int k = 20; k >= 1; k--) begin
      if (active[(32'(rr_idx_ff) + k) % 20]) begin
        rr_next = 5'((32'(rr_idx_ff) + k) % 20);
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rr_idx_ff <= 5'h00;
      rr_cnt_ff <= 8'h00;
    end else if (mode_ff == MODE_ROUND) begin
      if (!active[rr_idx_ff] || (tenth_tick && rr_cnt_ff + 8'h01 >= rr_time_ff)) begin
        rr_idx_ff <= rr_next;
        rr_cnt_ff <= 8'h00;
      end else if (tenth_tick) begin
        rr_cnt_ff <= rr_cnt_ff + 8'h01;
      end
    end
  end

  // display saver counts seconds of inactivity
  logic [16:0] idle_s_ff;
  logic saver_hit;
  assign saver_hit = saver_h_ff != 5'h00
                     && idle_s_ff >= 17'(saver_h_ff) * 17'(SEC_PER_HOUR);
  always_ff @(posedge clk_i) begin
    if (rst_i || display_activity_i || saver_h_ff == 5'h00) begin
      idle_s_ff <= 17'h00000;
    end else if (sec_tick && !saver_hit) begin
      idle_s_ff <= idle_s_ff + 17'h00001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msg_number_o <= 16'h0000;
      msg_valid_o <= 1'b0;
    end else if (saver_hit) begin
      msg_valid_o <= 1'b0;
      msg_number_o <= 16'h0000;
    end else begin
      unique case (mode_ff)
        MODE_ROUND: begin
          msg_number_o <= 16'(rr_idx_ff) + 16'h0001;
          msg_valid_o <= active[rr_idx_ff];
        end
        MODE_PRIO: begin
          msg_number_o <= 16'(prio_idx) + 16'h0001;
          msg_valid_o <= prio_any;
        end
        default: begin
          msg_number_o <= par_num;
          msg_valid_o <= 1'b1;
        end
      endcase
    end
  end

  // blink and rate timers on the tenth tick
  logic [7:0] blink_cnt_ff, chain_cnt_ff, up_cnt_ff, left_cnt_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt_ff <= 8'h00;
      blink_phase_o <= 1'b1;
    end else if (tenth_tick) begin
      if (blink_cnt_ff + 8'h01 >= (blink_phase_o ? blink_on_ff : blink_off_ff)) begin
        blink_cnt_ff <= 8'h00;
        blink_phase_o <= !blink_phase_o;
      end else begin
        blink_cnt_ff <= blink_cnt_ff + 8'h01;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain_cnt_ff <= 8'h00;
      up_cnt_ff <= 8'h00;
      left_cnt_ff <= 8'h00;
      chain_tick_o <= 1'b0;
      scroll_up_tick_o <= 1'b0;
      scroll_left_tick_o <= 1'b0;
    end else begin
      chain_tick_o <= tenth_tick && chain_cnt_ff + 8'h01 >= rate_chain_ff;
      scroll_up_tick_o <= tenth_tick && up_cnt_ff + 8'h01 >= rate_up_ff;
      scroll_left_tick_o <= tenth_tick && left_cnt_ff + 8'h01 >= rate_left_ff;
      if (tenth_tick) begin
        chain_cnt_ff <= (chain_cnt_ff + 8'h01 >= rate_chain_ff) ? 8'h00 : chain_cnt_ff + 8'h01;
        up_cnt_ff <= (up_cnt_ff + 8'h01 >= rate_up_ff) ? 8'h00 : up_cnt_ff + 8'h01;
        left_cnt_ff <= (left_cnt_ff + 8'h01 >= rate_left_ff) ? 8'h00 : left_cnt_ff + 8'h01;
      end
    end
  end

  // read mux is registered so data is stable with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (rd) begin
      unique case (adr_i)
        REG_PORT: dat_o <= {13'h0000, ctl_in_ff, mode_ff, deb_var_ff, 2'h0, deb_sel_ff,
                            1'b0, width_ff, code_ff, polarity_ff};
        REG_SERIAL: dat_o <= {29'h00000000, word8, par_even_ff, par_en_ff};
        REG_TIMES: dat_o <= {3'h0, saver_h_ff, blink_off_ff, blink_on_ff, rr_time_ff};
        REG_RATES: dat_o <= {8'h00, rate_left_ff, rate_up_ff, rate_chain_ff};
        REG_DATE: dat_o <= {9'h000, year_ff, 3'h0, day_ff, 4'h0, month_ff};
        REG_TIME: dat_o <= {1'b0, frozen_ff, 5'h00, fmt24_ff, 2'h0, pm,
                            fmt24_ff ? hour_ff : hour12, 2'h0, min_ff, 2'h0, sec_ff};
        REG_STATUS: dat_o <= {27'h0000000, HAS_WIDE, HAS_CLOCK, saver_hit, prio_any, refused_ff};
        REG_SEL: dat_o <= {12'h000, stable_ff};
        default: dat_o <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: sim/msel_front_checker.sv */
// checker for the message select front end
// sees only top ports; bound to the design from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module msel_front_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [15:0] msg_number_o,
  input wire logic msg_valid_o,
  input wire logic blink_phase_o,
  input wire logic chain_tick_o,
  input wire logic scroll_up_tick_o,
  input wire logic scroll_left_tick_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence seq_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence seq_answer;
    ack_o ##1 !ack_o;
  endsequence
  wb_answer_a: assert property (seq_take |=> seq_answer)
    else $error("ack not a single cycle after request");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  rdata_hold_a: assert property (!(ack_o && !we_i) |-> $stable(dat_o))
    else $error("read data moved outside a read");
  reset_state_a: assert property (disable iff (1'b0)
    rst_i |=> !ack_o && !msg_valid_o && blink_phase_o && msg_number_o == 16'h0000)
    else $error("outputs not at reset state");
  chain_pulse_a: assert property (chain_tick_o |=> !chain_tick_o)
    else $error("chain tick longer than a cycle");
  up_pulse_a: assert property (scroll_up_tick_o |=> !scroll_up_tick_o)
    else $error("scroll up tick longer than a cycle");
  left_pulse_a: assert property (scroll_left_tick_o |=> !scroll_left_tick_o)
    else $error("scroll left tick longer than a cycle");
  // one tenth is hundreds of cycles, so a phase can never flip within eight
  blink_hold_a: assert property ($changed(blink_phase_o) |=> $stable(blink_phase_o) [*8])
    else $error("blink phase shorter than a tenth");
  tick_gap_a: assert property ($rose(chain_tick_o) |=> !chain_tick_o [*8])
    else $error("chain ticks too close");
endmodule
`default_nettype wire

/* File: sim/field_outputs_model.sv */
// field discrete outputs feeding the parallel select inputs
// assumes the bench changes level_i just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module field_outputs_model (
  input wire logic clk_i,
  input wire logic [19:0] level_i,
  output logic [15:0] select_o,
  output logic [3:0] control_o
);
  logic [19:0] last_ff = 20'h00000;
  logic [2:0] chatter_ff = 3'h0;
  // contacts chatter after every change, so debounce must restart on them
  always_ff @(posedge clk_i) begin
    last_ff <= level_i;
    if (level_i != last_ff) begin
      chatter_ff <= 3'h5;
    end else if (chatter_ff != 3'h0) begin
      chatter_ff <= chatter_ff - 3'h1;
    end
  end
  always_comb begin
    {control_o, select_o} = chatter_ff[0] ? ~level_i : level_i;
  end
endmodule
`default_nettype wire

/* File: sim/parallel_message_select_input_tb.sv */
// self-checking bench for the message select front end
// one 25 MHz clock; ms count shortened to 4 cycles
`timescale 1ns/1ps
`default_nettype none
module parallel_message_select_input_tb;
  import msel_pkg::*;
  localparam int unsigned MSC = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [19:0] level = 20'h0;
  logic [15:0] lines;
  logic [3:0] ctl;
  logic [15:0] msg;
  logic [31:0] rd;
  logic [31:0] rdat2;
  logic [31:0] rd2;
  logic valid;
  logic [15:0] v;
  logic [15:0] prev;
  logic [15:0] exp;
  int dms[3] = '{5, 47, 30};
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed;
  msel_front #(.MS_CNT(MSC)) msel_front_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .discrete_select_inputs_i(lines), .control_lines_i(ctl),
    .display_activity_i(1'b1), .msg_number_o(msg), .msg_valid_o(valid), .blink_phase_o(),
    .chain_tick_o(), .scroll_up_tick_o(), .scroll_left_tick_o());
  field_outputs_model field_outputs_model_i (.clk_i(clk_i), .level_i(level),
    .select_o(lines), .control_o(ctl));
  // a unit without clock and wide port sees the same bus traffic, to catch refusals
  msel_front #(.HAS_CLOCK(1'b0), .HAS_WIDE(1'b0), .MS_CNT(MSC)) msel_front_lite_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat2), .ack_o(), .discrete_select_inputs_i(lines),
    .control_lines_i(ctl), .display_activity_i(1'b1), .msg_number_o(), .msg_valid_o(),
    .blink_phase_o(), .chain_tick_o(), .scroll_up_tick_o(), .scroll_left_tick_o());
  always #20 clk_i = ~clk_i;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      @(posedge clk_i);
      n++;
    end
    rd = rdat;
    rd2 = rdat2;
    chk(32'(n), 32'h1); // registered ack gives one wait state
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic drive(input logic [19:0] lv, input int n);
    level <= lv;
    repeat (n) @(posedge clk_i);
  endtask
  function automatic logic [31:0] port(logic pol, logic code, logic wid, logic [1:0] deb,
      logic [1:0] mode, logic ctl_in);
    return {13'h0, ctl_in, mode, 8'd30, 2'h0, deb, 1'b0, wid, code, pol};
  endfunction
  function automatic logic [15:0] bcd(logic [15:0] x);
    return 16'(x[15:12] * 1000 + x[11:8] * 100 + x[7:4] * 10 + x[3:0]);
  endfunction
  function automatic logic [15:0] prio(logic [15:0] x);
    for (int k = 0; k < 16; k++) begin
      if (x[k]) begin
        return 16'(k + 1);
      end
    end
    return 16'h0000;
  endfunction
  initial begin
    seed = $urandom(27);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rchk(REG_PORT, 32'h00030003, 32'h0);
    rchk(REG_TIMES, 32'h1fffffff, 32'h00050505);
    rchk(6'h20, 32'hffffffff, 32'h0);
    wb(1'b1, REG_SERIAL, 32'h1);
    rchk(REG_SERIAL, 32'h7, 32'h1);
    wb(1'b1, REG_SERIAL, 32'h3);
    rchk(REG_SERIAL, 32'h7, 32'h3);
    wb(1'b1, REG_SERIAL, 32'h2);
    rchk(REG_SERIAL, 32'h4, 32'h4);
    wb(1'b1, REG_TIMES, 32'h1f050505);
    rchk(REG_TIMES, 32'h1fffffff, 32'h18050505);
    wb(1'b1, REG_RATES, 32'h00ff0000);
    rchk(REG_RATES, 32'h00ffffff, 32'h00ff0101);
    $display("test registers done");
    prev = 16'hffff;
    drive(20'h0, 300);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, REG_PORT, port(1'b1, 1'b1, 1'b1, 2'(i + 1), 2'd0, 1'b0));
      v = prev ^ (16'($urandom) | 16'h0001);
      drive({4'h0, v}, dms[i] * MSC / 2);
      rchk(REG_SEL, 32'hffff, {16'h0, prev});
      drive({4'h0, v}, dms[i] * MSC + 40);
      rchk(REG_SEL, 32'hffff, {16'h0, v});
      prev = v;
    end
    wb(1'b1, REG_PORT, port(1'b0, 1'b1, 1'b1, 2'd1, 2'd0, 1'b0));
    drive({4'h0, v}, 100);
    rchk(REG_SEL, 32'hffff, {16'h0, ~v});
    $display("test debounce done");
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, REG_PORT, port(1'b1, i[0], i < 4, 2'd1, 2'd0, 1'b0));
      v = 16'($urandom);
      for (int k = 0; k < 4; k++) begin
        v[k*4 +: 4] = i[0] ? v[k*4 +: 4] : 4'($urandom % 10);
      end
      drive({4'h0, v}, 100);
      exp = (i < 4) ? v : {8'h0, v[7:0]};
      exp = i[0] ? exp : bcd(exp);
      chk({16'h0, msg}, {16'h0, exp});
    end
    wb(1'b1, REG_PORT, port(1'b1, 1'b1, 1'b1, 2'd1, 2'd2, 1'b0));
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 16'h8001 : (i == 1) ? 16'h8000 : (16'($urandom) | 16'h0100);
      drive({4'($urandom), v}, 100);
      chk({16'h0, msg}, {16'h0, prio(v)});
    end
    wb(1'b1, REG_PORT, port(1'b1, 1'b1, 1'b1, 2'd1, 2'd2, 1'b1));
    drive(20'h20000, 100);
    chk({16'h0, msg}, 32'h12);
    rchk(REG_STATUS, 32'h1, 32'h0);
    chk(rd2 & 32'h11, 32'h1);
    drive(20'h0, 100);
    chk({31'h0, valid}, 32'h0);
    wb(1'b1, REG_PORT, port(1'b1, 1'b1, 1'b1, 2'd1, 2'd1, 1'b0));
    exp = 16'h0;
    for (int i = 0; i < 50; i++) begin
      drive(20'h00005, 100);
      chk({16'h0, msg & 16'hfffd}, 32'h1);
      exp = exp | (16'h1 << msg[1]);
    end
    chk({16'h0, exp}, 32'h3);
    $display("test select modes done");
    wb(1'b1, REG_DATE, 32'h00631f0c);
    rchk(REG_DATE, 32'h007f1f0f, 32'h00631f0c);
    chk(rd2, 32'h00000101);
    wb(1'b1, REG_TIME, 32'h81010203);
    wb(1'b1, REG_TIME, 32'h40000000);
    repeat (12000) @(posedge clk_i);
    rchk(REG_TIME, 32'h001f3f3f, 32'h00010203);
    wb(1'b1, REG_TIME, 32'h81173b3a);
    rchk(REG_TIME, 32'h001f3f3f, 32'h00173b3a);
    // 8000 edges after the load hold exactly two second ticks: 23:59:58 rolls to 00:00:00
    repeat (7996) @(posedge clk_i);
    rchk(REG_TIME, 32'h001f3f3f, 32'h00000000);
    rchk(REG_STATUS, 32'h19, 32'h18);
    chk(rd2 & 32'h19, 32'h1);
    $display("test clock done");
    complete_run();
  end
endmodule
bind msel_front msel_front_checker msel_front_checker_i (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o),
  .msg_number_o(msg_number_o), .msg_valid_o(msg_valid_o), .blink_phase_o(blink_phase_o),
  .chain_tick_o(chain_tick_o), .scroll_up_tick_o(scroll_up_tick_o),
  .scroll_left_tick_o(scroll_left_tick_o));
`default_nettype wire
